/* hw/infrared_pulse_codec.sv */
// infrared pulse encoder and decoder between uart and transceiver
// Functional notes
// (R1) encode uart tx bits into pulses when enabled
// (R2) half-duplex; never transmit and receive together; receive is blocked only while a zero bit is in flight
// (R3) bit rate from uart baud generator divisor
// (R4) software keeps rates 9600 to 115.2k
// (R5) uart must be enabled when codec used
// (R6) each bit spans 16 baud clocks
// (R7) tx one: output low whole bit
// (R8) tx zero: 7 low, 3 high, 6 low
// (R9) enabled: modulated signal drives transmit pin
// (R10) demodulate receive pulses, timed by baud clock
// (R11) enabled: receive pin feeds decoder not uart
// (R12) receive counter runs 0 to 15
// (R13) uart input lags pulse stream 8 clocks
// (R14) falling edge on input resets counter
// (R15) at count 8 update uart input
// (R16) window opens at 12, closes at 8
// (R17) no pulse: back to idle, await edge
// (R18) resync leaves uart receiver undisturbed
// (R19) software enables codec before pin function
// (R20) system clock at least 1.0 MHz
// (R21) pulse decodes zero, no pulse decodes one
// (R22) disabled: uart wired straight to pins
`timescale 1ns/1ps
module infrared_pulse_codec
   import ir_codec_pkg::*;
(
   // clock and reset
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_rst,
   // control
   input  wire logic                       i_codec_enable_bit,
   input  wire logic                       i_baud_tick,
   // uart side
   input  wire ir_codec_pkg::uart_serial_t i_uart,
   output logic                            o_uart_rxd,
   // pins
   output logic                            o_txd_pin,
   input  wire logic                       i_rxd_pin
);
   import ir_codec_pkg::*;

   // transmit side
   logic [3:0] tx_cnt_q;
   logic       tx_bit_q;
   logic       tx_busy_q;
   logic       pin_q;
   logic       tx_pulse;

   // receive side
   rx_state_t  rx_state_q;
   logic [3:0] rx_cnt_q;
   logic       rx_prev_q;
   logic       rx_seen_q;
   logic       rxd_q;
   logic       fall;
   logic       fall_take;
   logic [4:0] lag_q;
   logic       tx_line_ok;

   assign tx_line_ok = ~tx_busy_q;

   // bit slots free-run on the baud tick so uart bit edges stay aligned
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_cnt_q <= RESET_COUNT;
         tx_bit_q <= RESET_LINE;
      end else if (i_baud_tick) begin
         tx_cnt_q <= tx_cnt_q + 4'h1; // [R6] [R3]
         if (tx_cnt_q == RX_COUNT_MAX) begin
            tx_bit_q <= i_uart.txd; // [R1]
         end
      end
   end

   // pulse high in slots 7 to 9 of a zero bit
   always_comb begin
      tx_pulse = ~tx_bit_q && (tx_cnt_q >= TX_PULSE_START) && (tx_cnt_q < TX_PULSE_END); // [R7] [R8]
   end

   // a zero bit in flight marks the link busy for transmit
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_busy_q <= 1'b0;
      end else begin
         tx_busy_q <= i_codec_enable_bit && ~tx_bit_q;
      end
   end

   // pin mux, registered so the pin comes from a flip-flop
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_q <= 1'b0;
      end else if (i_codec_enable_bit) begin
         pin_q <= tx_pulse; // [R9]
      end else begin
         pin_q <= i_uart.txd; // [R22]
      end
   end

   assign fall = rx_prev_q & ~i_rxd_pin;
   // edges before count 12 of the first bit are noise, not a new pulse
   // in the window state only counts below 8 are still inside the window
   assign fall_take = fall && (rx_state_q == RX_IDLE || rx_cnt_q >= RX_WINDOW_OPEN
                               || (rx_state_q == RX_WINDOW && rx_cnt_q < RX_UPDATE_COUNT)); // [R16]

   // edge detector on the receive pin; pin is synchronous by contract
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_prev_q <= 1'b0;
      end else begin
         rx_prev_q <= i_rxd_pin;
      end
   end

   // decoder counter and state
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q   <= RESET_COUNT;
         rx_seen_q  <= 1'b0;
      end else if (!i_codec_enable_bit || !tx_line_ok) begin
         // ignoring our own echo keeps the link half-duplex
         rx_state_q <= RX_IDLE; // [R2]
         rx_cnt_q   <= RESET_COUNT;
         rx_seen_q  <= 1'b0;
      end else if (fall_take) begin
         rx_cnt_q   <= RESET_COUNT; // [R14] [R11]
         rx_seen_q  <= 1'b1;
         rx_state_q <= RX_FIRST;
      end else if (i_baud_tick && rx_state_q != RX_IDLE) begin
         rx_cnt_q <= rx_cnt_q + 4'h1; // [R12] [R10]
         if (rx_cnt_q == RX_COUNT_MAX) begin
            rx_state_q <= RX_WINDOW;
         end
         if (rx_cnt_q + 4'h1 == RX_UPDATE_COUNT && rx_state_q == RX_WINDOW) begin
            // window closed with no pulse
            rx_seen_q  <= 1'b0;
            if (!rx_seen_q) begin
               rx_state_q <= RX_IDLE; // [R17] [R16]
            end
         end else if (rx_cnt_q + 4'h1 == RX_UPDATE_COUNT) begin
            rx_seen_q <= 1'b0;
         end
      end
   end

   // uart input follows the decoded bit at count 8
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rxd_q <= RESET_LINE;
      end else if (!i_codec_enable_bit) begin
         rxd_q <= i_rxd_pin; // [R22]
      end else if (i_baud_tick && rx_state_q != RX_IDLE
                   && rx_cnt_q + 4'h1 == RX_UPDATE_COUNT) begin
         rxd_q <= ~rx_seen_q; // [R15] [R13] [R21] [R18]
      end else if (rx_state_q == RX_IDLE) begin
         rxd_q <= RESET_LINE; // [R21]
      end
   end

   // ticks since the last accepted edge; only the checks below read it
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         lag_q <= 5'h00;
      end else if (i_codec_enable_bit && tx_line_ok && fall_take) begin
         lag_q <= 5'h00;
      end else if (i_baud_tick && lag_q != LAG_MAX) begin
         lag_q <= lag_q + 5'h01;
      end
   end

   assign o_txd_pin  = pin_q;
   assign o_uart_rxd = rxd_q;

   a_one_stays_low: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R7]
      (i_codec_enable_bit && tx_bit_q) |=> !o_txd_pin)
      else $error("one bit produced a pulse");

   a_pulse_placed: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R8]
      (i_codec_enable_bit && $past(i_codec_enable_bit) && o_txd_pin)
      |-> ($past(tx_cnt_q) >= TX_PULSE_START && $past(tx_cnt_q) < TX_PULSE_END))
      else $error("pulse outside 7..9 slot");

   a_bypass_tx: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R22]
      !i_codec_enable_bit |=> o_txd_pin == $past(i_uart.txd))
      else $error("bypass transmit mismatch");

   a_bypass_rx: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R22]
      (!i_codec_enable_bit && $past(!i_codec_enable_bit)) |-> o_uart_rxd == $past(i_rxd_pin))
      else $error("bypass receive mismatch");

   a_fall_resets: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R14]
      (i_codec_enable_bit && tx_line_ok && fall_take) |=> rx_cnt_q == RESET_COUNT)
      else $error("falling edge did not reset counter");

   a_update_at_8: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R15]
      (i_codec_enable_bit && $changed(o_uart_rxd) && $past(rx_state_q) != RX_IDLE
       && $past(i_codec_enable_bit)) |-> $past(rx_cnt_q) == 4'h7)
      else $error("uart input changed away from count 8");

   a_busy_no_rx: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R2]
      tx_busy_q |=> rx_state_q == RX_IDLE)
      else $error("receive active while transmitting");

   a_slot_ticks: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R6]
      i_baud_tick |=> tx_cnt_q == $past(tx_cnt_q) + 4'h1)
      else $error("bit slot counter did not advance");

   // encoder and decoder checks; the lag checks count from the last accepted falling edge
   a_idle_rxd_high: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R17]
      (i_codec_enable_bit
       && rx_state_q == RX_IDLE)
      |=> o_uart_rxd)
      else $error("idle decoder left uart input low");

   a_off_rx_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R22]
      (!i_codec_enable_bit
       && !i_rst)
      |=> rx_state_q == RX_IDLE)
      else $error("decoder active while codec disabled");

   a_window_close: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R16]
      (i_codec_enable_bit && tx_line_ok && !fall_take && i_baud_tick && rx_state_q == RX_WINDOW
       && rx_cnt_q + 4'h1 == RX_UPDATE_COUNT && !rx_seen_q)
      |=> rx_state_q == RX_IDLE)
      else $error("window did not close at count 8");

   a_first_to_window: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R16]
      (i_codec_enable_bit && tx_line_ok && !fall_take && i_baud_tick
       && rx_state_q == RX_FIRST && rx_cnt_q == RX_COUNT_MAX)
      |=> rx_state_q == RX_WINDOW)
      else $error("window state not entered after count 15");

   a_zero_decoded: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R21]
      (i_codec_enable_bit && i_baud_tick && rx_state_q != RX_IDLE
       && rx_cnt_q + 4'h1 == RX_UPDATE_COUNT && rx_seen_q)
      |=> !o_uart_rxd)
      else $error("pulse not decoded as zero");

   a_one_decoded: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R21]
      (i_codec_enable_bit && i_baud_tick && rx_state_q != RX_IDLE
       && rx_cnt_q + 4'h1 == RX_UPDATE_COUNT && !rx_seen_q)
      |=> o_uart_rxd)
      else $error("missing pulse not decoded as one");

   a_tx_bit_latch: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R1]
      (i_baud_tick
       && tx_cnt_q == RX_COUNT_MAX)
      |=> tx_bit_q == $past(i_uart.txd))
      else $error("uart bit not taken at slot end");

   a_pulse_start: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R8]
      (i_codec_enable_bit && !tx_bit_q
       && tx_cnt_q == TX_PULSE_START)
      |=> o_txd_pin)
      else $error("zero bit pulse missing at slot 7");

   a_pulse_end: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R8]
      (i_codec_enable_bit
       && tx_cnt_q == TX_PULSE_END)
      |=> !o_txd_pin)
      else $error("pulse still high at slot 10");

   a_pin_low_outside: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R8]
      (i_codec_enable_bit
       && (tx_cnt_q < TX_PULSE_START || tx_cnt_q >= TX_PULSE_END))
      |=> !o_txd_pin)
      else $error("pin high outside pulse slots");

   a_idle_fall_starts: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R14]
      (i_codec_enable_bit && tx_line_ok
       && fall && rx_state_q == RX_IDLE)
      |=> rx_state_q == RX_FIRST)
      else $error("falling edge did not start decoder");

   a_echo_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R2]
      (i_codec_enable_bit
       && !tx_line_ok)
      |=> rx_cnt_q == RESET_COUNT)
      else $error("receive counter ran during transmit");

   a_early_fall_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R16]
      (i_codec_enable_bit && tx_line_ok && fall && !fall_take
       && !i_baud_tick && rx_state_q != RX_IDLE)
      |=> rx_cnt_q == $past(rx_cnt_q))
      else $error("edge outside window moved the counter");

   a_busy_tracks: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R2]
      (i_codec_enable_bit
       && !tx_bit_q)
      |=> tx_busy_q)
      else $error("zero bit in flight not marked busy");

   a_lag_update: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R13]
      (i_codec_enable_bit && $past(i_codec_enable_bit)
       && $fell(o_uart_rxd) && $past(rx_state_q) != RX_IDLE)
      |-> $past(lag_q) == LAG_UPDATE)
      else $error("uart input not 8 ticks behind edge");

   a_lag_close: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R16]
      (i_codec_enable_bit && $past(i_codec_enable_bit)
       && $rose(o_uart_rxd) && $past(rx_state_q) != RX_IDLE)
      |-> $past(lag_q) == LAG_CLOSE)
      else $error("window did not close 24 ticks after edge");

   a_count_wraps: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R12]
      (i_codec_enable_bit && tx_line_ok && !fall_take && i_baud_tick
       && rx_state_q != RX_IDLE && rx_cnt_q == RX_COUNT_MAX)
      |=> rx_cnt_q == RESET_COUNT)
      else $error("receive counter did not wrap after 15");

   a_rx_count_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R12]
      (i_codec_enable_bit && tx_line_ok
       && !fall_take && !i_baud_tick)
      |=> rx_cnt_q == $past(rx_cnt_q))
      else $error("receive counter moved without a tick");

   a_seen_on_fall: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R21]
      (i_codec_enable_bit && tx_line_ok
       && fall_take)
      |=> rx_seen_q)
      else $error("accepted edge not recorded as pulse");

   a_tx_slot_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R6]
      (!i_baud_tick
       && !i_rst)
      |=> tx_cnt_q == $past(tx_cnt_q))
      else $error("bit slot counter moved without a tick");

   a_bit_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R6]
      (!i_baud_tick
       || tx_cnt_q != RX_COUNT_MAX)
      |=> $stable(tx_bit_q))
      else $error("transmit bit changed inside its slot");

   a_idle_no_count: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R17]
      (i_codec_enable_bit && tx_line_ok
       && !fall_take && rx_state_q == RX_IDLE)
      |=> rx_cnt_q == $past(rx_cnt_q))
      else $error("idle decoder counter moved");
endmodule

/* include/ir_codec_pkg.sv */
// constants and carrier types for the infrared pulse codec
package ir_codec_pkg;
   localparam int unsigned BIT_CLOCKS      = 16;   // baud clocks per bit
   localparam logic [3:0]  TX_PULSE_START  = 4'h7; // pulse begins after 7 low clocks
   localparam logic [3:0]  TX_PULSE_END    = 4'hA; // 3 clocks high, then 6 low
   localparam logic [3:0]  RX_UPDATE_COUNT = 4'h8;
   localparam logic [3:0]  RX_WINDOW_OPEN  = 4'hC;
   localparam logic [3:0]  RX_COUNT_MAX    = 4'hF;
   localparam logic        RESET_LINE      = 1'b1; // idle uart line is high
   localparam logic [3:0]  RESET_COUNT     = 4'h0;
   localparam logic [4:0]  LAG_UPDATE      = 5'h07; // ticks from edge to uart update
   localparam logic [4:0]  LAG_CLOSE       = 5'h17; // ticks from edge to window close
   localparam logic [4:0]  LAG_MAX         = 5'h1F;

   // decoder states along the usual path
   typedef enum logic [1:0] {
      RX_IDLE   = 2'b00,
      RX_FIRST  = 2'b01,
      RX_WINDOW = 2'b11
   } rx_state_t;

   // uart-side serial pair
   typedef struct packed {
      logic txd;
      logic rxd;
   } uart_serial_t;
endpackage

/* tb/ir_transceiver_model.sv */
// transceiver model replaying a bit stream as pulses on the receive pin
`timescale 1ns/1ps
module ir_transceiver_model (
   // clocking
   input  wire logic i_ref_clk,
   input  wire logic i_baud_tick,
   // bit to send
   input  wire logic i_send,
   input  wire logic i_bit,
   // pin
   output logic      o_pulse
);
   logic [3:0] slot_q = 4'h0;
   always_ff @(posedge i_ref_clk) begin
      if (i_baud_tick) begin
         slot_q <= i_send ? slot_q + 4'h1 : 4'h0;
      end
   end
   // line rests low outside pulses, so a stale level never reads as data
   assign o_pulse = i_send && !i_bit && slot_q >= 4'h7 && slot_q <= 4'h9;
endmodule

/* tb/tb_top.sv */
// self-checking bench for the infrared pulse codec
`timescale 1ns/1ps
module tb_top;
   import ir_codec_pkg::*;
   logic         clk = 0, rst = 1, en = 0, tick = 0, send = 0, pbit = 1, pin, o_rx, o_tx, pv;
   uart_serial_t uart = '{txd: 1'b1, rxd: 1'b1};
   logic [1:0]   div = 2'h0;
   int           n_errors = 0, n_checks = 0, seed = 32'hcb2f, wt = 0, wr = 0, run = 0;
   int           txq[$], rxq[$];
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      div <= div + 2'h1;
      tick <= #1 (div == 2'h3); // fast rate, outside standard but legal
   end
   infrared_pulse_codec uut (.i_ref_clk(clk), .i_rst(rst), .i_codec_enable_bit(en), .i_baud_tick(tick),
      .i_uart(uart), .o_uart_rxd(o_rx), .o_txd_pin(o_tx), .i_rxd_pin(pin));
   ir_transceiver_model xcvr (.i_ref_clk(clk), .i_baud_tick(tick), .i_send(send), .i_bit(pbit), .o_pulse(pin));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // tick generator never stops, so these waits are bounded
   task automatic tick_wait(input int n);
      repeat (n) @(posedge clk iff tick);
      #1;
   endtask
   // widths counted in baud ticks while the output sits away from idle
   always @(posedge clk) begin
      if (en && tick && o_tx) wt++;
      if (en && tick && !o_rx) wr++;
      if (!o_tx && wt != 0) begin
         check(8'(wt), 8'(txq.pop_front()));
         wt = 0;
      end
      if (o_rx && wr != 0) begin
         check(8'(wr), 8'(rxq.pop_front()));
         wr = 0;
      end
   end
   initial begin
      #500000;
      n_errors++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk);
      check(o_tx, 0);
      check(o_rx, 1);
      #1 rst = 0;
      en = 1;
      for (int i = 0; i < 12; i++) begin
         uart.txd = 1'($random(seed));
         if (!uart.txd) txq.push_back(3);
         tick_wait(16);
      end
      uart.txd = 1;
      tick_wait(32);
      check(8'(txq.size()), 0);
      $display("transmit test done");
      send = 1; // far side sends only while our transmitter idles
      for (int i = 0; i < 13; i++) begin
         pbit = (i == 12) ? 1'b1 : 1'($random(seed));
         if (!pbit) run++;
         else if (run != 0) begin
            rxq.push_back(16 * run);
            run = 0;
         end
         tick_wait(16);
      end
      tick_wait(32);
      check(8'(rxq.size()), 0);
      $display("receive test done");
      en = 0;
      for (int i = 0; i < 200; i++) begin
         uart.txd = 1'($random(seed));
         pbit = 1'($random(seed));
         @(posedge clk);
         pv = pin;
         #1;
         check(o_tx, uart.txd);
         check(o_rx, pv);
      end
      $display("bypass test done");
      summarize();
   end
endmodule
